/* jtx_defines.svh */
// constants for the serial link transmitter: characters, counts, timing, mode fields
`ifndef JTX_DEFINES_SVH
`define JTX_DEFINES_SVH

// clock and timing
`define CLK_PERIOD_NS 10
`define SYNC_MIN_LOW_NS 90

// control characters (octet value before line encoding)
`define K28_0 8'h1C
`define K28_3 8'h7C
`define K28_4 8'h9C
`define K28_5 8'hBC
`define K28_7 8'hFC

// framing counts
`define ILAS_LAST_MF 2'h3
`define BLOCK_OCTETS 8'h08
`define MB_BLOCKS 9'h020

// legal frames-per-multiframe window, as K*F and K
`define KF_MIN 17'h00011
`define KF_MAX 17'h00400
`define K_MAX 9'h100

// mode select fields
`define MODE_ENC_BIT 4

// scrambler seed, taps and sync header
`define SCRAMBLE_SEED 58'h000000000007F80
`define SCR8_TAP_A 13
`define SCR8_TAP_B 14
`define SCR66_TAP_A 38
`define SCR66_TAP_B 57
`define SH_DATA 2'h1

`endif

/* jtx_pkg.sv */
// types shared by the link transmitter modules
package jtx_pkg;

  // link bring-up states, one-hot
  typedef enum logic [3:0] {
    ST_CGS       = 4'b0001,
    ST_WAIT_LMFC = 4'b0010,
    ST_ILAS      = 4'b0100,
    ST_DATA      = 4'b1000
  } link_state_t;

endpackage

/* jtx_scr_if.sv */
// octet path between the link controller and the lane scramblers
`timescale 1ns/1ps
`default_nettype none
interface jtx_scr_if #(parameter int LANES = 4) ();
  logic [LANES*8-1:0] din;
  logic [LANES*8-1:0] dout;
  logic adv;
  logic bypass;
  logic enc66;
  modport link (output din, output adv, output bypass, output enc66, input dout);
  modport scr (input din, input adv, input bypass, input enc66, output dout);
endinterface
`default_nettype wire

/* jtx_scrambler.sv */
// per-lane self-synchronous scramblers for both line encodings
`timescale 1ns/1ps
`default_nettype none
`include "jtx_defines.svh"
module jtx_scrambler #(
  parameter int LANES = 4
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // octet path
  jtx_scr_if.scr scr_port
);

  typedef struct packed {
    logic [LANES-1:0][57:0] lfsr;
  } scr_st_t;

  scr_st_t st;
  scr_st_t next_st;

  // scramble one octet msb first, returns {new state, octet}
  function automatic logic [65:0] scr_step(input logic [57:0] s, input logic [7:0] d,
                                           input logic enc66);
    logic [57:0] t;
    logic [7:0] o;
    logic b;
    t = s;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ (enc66 ? (t[`SCR66_TAP_A] ^ t[`SCR66_TAP_B])
                        : (t[`SCR8_TAP_A] ^ t[`SCR8_TAP_B])); // RULE21
      o[i] = b;
      t = {t[56:0], b};
    end
    return {t, o};
  endfunction

  // scramble before encoding, state advances only on data
  always_comb begin
    logic [65:0] r;
    r = 66'h0;
    next_st = st;
    for (int l = 0; l < LANES; l++) begin
      r = scr_step(st.lfsr[l], scr_port.din[l*8 +: 8], scr_port.enc66); // RULE19
      scr_port.dout[l*8 +: 8] = scr_port.bypass ? scr_port.din[l*8 +: 8] : r[7:0];
      if (scr_port.adv && !scr_port.bypass) begin
        next_st.lfsr[l] = r[65:8];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st <= {LANES{`SCRAMBLE_SEED}};
    end else begin
      st <= next_st;
    end
  end

  scr_hold_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE19
    !scr_port.adv |=> st.lfsr == $past(st.lfsr))
    else $error("scrambler state moved without data");

endmodule // jtx_scrambler
`default_nettype wire

/* jtx_skid_buf.sv */
// small valid/ready buffer in front of the lane mapper
`timescale 1ns/1ps
`default_nettype none
module jtx_skid_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic rdy;
    logic vld;
  } fifo_st_t;

  fifo_st_t st;
  fifo_st_t next_st;

  // push, pop and flag update
  always_comb begin
    logic push;
    logic pop;
    push = i_valid && st.rdy;
    pop = st.vld && i_ready;
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = i_data;
      next_st.wp = st.wp + AW'(1);
    end
    if (pop) begin
      next_st.rp = st.rp + AW'(1);
    end
    next_st.cnt = st.cnt + CW'(push) - CW'(pop);
    next_st.rdy = next_st.cnt != CW'(DEPTH);
    next_st.vld = next_st.cnt != CW'(0);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st <= '0;
      st.rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_ready = st.rdy;
  assign o_valid = st.vld;
  assign o_data = st.mem[st.rp];

  fifo_bound_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.cnt == CW'(DEPTH) |-> !o_ready)
    else $error("buffer accepts while full");

endmodule // jtx_skid_buf
`default_nettype wire

/* jtx_link_tx.sv */
// serial link transmitter: lane mapping, framing, scrambling and bring-up
// Summary of operation
// [RULE1] lanes use either 8b/10b or 64b/66b framing, picked by mode select
// [RULE2] 8b/10b output keeps the older revision's characters and sequence
// [RULE3] up to four lanes may carry data to lower each lane's rate
// [RULE4] 64b/66b block alignment comes from sync headers, not the sync pin
// [RULE5] sync pin low in 8b/10b starts code group synchronisation
// [RULE6] in 64b/66b the sync pin is ignored except as oscillator sync
// [RULE7] a sysref edge resets the multiframe or extended multiblock counters
// [RULE8] one device clock runs all framing logic and the serializer feed
// [RULE9] optional forward error correction is available in 64b/66b mode
// [RULE10] no 64b/80b layer, no command channel, no three-bit crc
// [RULE11] subclass 1 transmitter, also usable by subclass 0 receivers
// [RULE12] lanes of one link stay aligned; no multipoint alignment
// [RULE13] sync pin timing works for both older signalling conventions
// [RULE14] samples travel as octets, F octets a frame, frames over L lanes
// [RULE15] N-bit samples sent as N' fields, M converters, S samples each
// [RULE16] one mode select setting fixes the lane and frame parameters; here it sets lanes and encoding only, F and K are separate inputs
// [RULE17] frames group into multiframes, or blocks and multiblocks
// [RULE18] scrambling optional in 8b/10b, always on in 64b/66b
// [RULE19] scramble octets before 10-bit coding, blocks before sync header
// [RULE20] the lane alignment sequence is never scrambled
// [RULE21] each encoding uses its own published scrambler polynomial
// [RULE22] the receiver locks its descrambler without any seed exchange
// [RULE23] while sync is low every lane sends comma characters
// [RULE24] after sync rises, alignment starts at the next multiframe edge
// [RULE25] alignment spans four multiframes, each opening K28.0, closing K28.3
// [RULE26] frames per multiframe lies between ceil(17/F) and min(256, 1024/F)
// [RULE27] each scrambled 64-bit block gets a two-bit sync header
`timescale 1ns/1ps
`default_nettype none
`include "jtx_defines.svh"
module jtx_link_tx #(
  parameter int LANES = 4
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // pins from the receiver and the clock tree
  input wire logic i_link_sync_request_pin_n,
  input wire logic i_sysref,
  // configuration
  input wire logic [4:0] i_transport_mode_select,
  input wire logic i_scramble_enable,
  input wire logic i_fec_enable,
  input wire logic i_sync_is_osc_sync,
  input wire logic [7:0] i_frame_octets,
  input wire logic [8:0] i_frames_per_mf,
  input wire logic [5:0] i_mb_per_emb,
  // sample octets, already packed into frames
  input wire logic i_smp_valid,
  input wire logic [LANES*8-1:0] i_smp_data,
  output logic o_smp_ready,
  // lane outputs to the serializers
  output logic o_tx_valid,
  output logic [LANES*8-1:0] o_tx_octets,
  output logic [LANES-1:0] o_tx_is_k,
  output logic [LANES*2-1:0] o_tx_sh,
  output logic o_tx_block_start,
  output logic [LANES-1:0] o_lanes_active,
  // status
  output logic [3:0] o_link_state,
  output logic o_lmfc_edge,
  output logic o_osc_sync,
  output logic o_cfg_error
);

  localparam int SYNC_MIN_CYC = (`SYNC_MIN_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  typedef struct packed {
    logic sync_m;
    logic sync_s;
    logic sync_d;
    logic sref_m;
    logic sref_s;
    logic sref_d;
    logic enc_d;
    jtx_pkg::link_state_t state;
    logic [7:0] oct;
    logic [8:0] frm;
    logic [5:0] emb;
    logic [1:0] ilas_mf;
    logic [7:0] low_cnt;
    logic [LANES-1:0][7:0] prev_last;
    logic [LANES-1:0] fec_par;
    logic tx_valid;
    logic [LANES-1:0][7:0] tx_oct;
    logic [LANES-1:0] tx_k;
    logic [LANES-1:0][1:0] tx_sh;
    logic blk_start;
    logic [LANES-1:0] lanes_act;
    logic lmfc_edge;
    logic osc_sync;
    logic cfg_err;
  } link_st_t;

  link_st_t st;
  link_st_t next_st;

  logic buf_vld;
  logic [LANES*8-1:0] buf_data;
  logic buf_rdy;
  logic enc66;

  jtx_scr_if #(.LANES(LANES)) scr_bus ();

  // number of lanes in use for a mode select setting
  function automatic logic [2:0] lane_num(input logic [1:0] sel);
    logic [2:0] n;
    case (sel)
      2'h0: n = 3'h1;
      2'h1: n = 3'h2;
      default: n = 3'h4;
    endcase
    if (n > 3'(LANES)) begin
      n = 3'(LANES);
    end
    return n;
  endfunction

  // alignment sequence character for a position, {is_k, octet}
  function automatic logic [8:0] ilas_char(input logic [1:0] mf, input logic [7:0] oct,
                                           input logic [8:0] frm, input logic last,
                                           input logic [7:0] f, input logic [8:0] k,
                                           input logic [2:0] nl);
    logic [8:0] c;
    c = {1'b0, oct};
    if (oct == 8'h00 && frm == 9'h000) begin
      c = {1'b1, `K28_0};
    end else if (last) begin
      c = {1'b1, `K28_3};
    end else if (mf == 2'h1 && frm == 9'h000) begin
      case (oct)
        8'h01: c = {1'b1, `K28_4};
        8'h02: c = {1'b0, 5'h00, nl - 3'h1};
        8'h03: c = {1'b0, f - 8'h01};
        8'h04: c = {1'b0, k[7:0] - 8'h01};
        default: c = {1'b0, oct};
      endcase
    end
    return c;
  endfunction

  assign enc66 = i_transport_mode_select[`MODE_ENC_BIT]; // RULE1 RULE16

  // input buffer: drained only once data flows, so bring-up stalls the source
  jtx_skid_buf #(.WIDTH(LANES*8), .DEPTH(2)) u_buf (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_valid(i_smp_valid),
    .i_data(i_smp_data), // RULE14 RULE15
    .o_ready(buf_rdy),
    .o_valid(buf_vld),
    .o_data(buf_data),
    .i_ready(st.state == jtx_pkg::ST_DATA)
  );

  // scrambler feed: data only, alignment characters bypass it
  assign scr_bus.din = buf_vld ? buf_data : '0;
  assign scr_bus.adv = st.state == jtx_pkg::ST_DATA; // RULE20
  assign scr_bus.bypass = !(enc66 || i_scramble_enable); // RULE18
  assign scr_bus.enc66 = enc66; // RULE21

  jtx_scrambler #(.LANES(LANES)) u_scr (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .scr_port(scr_bus.scr)
  );

  // framing counters, bring-up sequencer and lane character selection
  always_comb begin
    logic [7:0] oct_lim;
    logic [8:0] frm_lim;
    logic [5:0] emb_lim;
    logic oct_last;
    logic frm_last;
    logic mf_last;
    logic sref_rise;
    logic resync;
    logic [2:0] nl;
    logic [16:0] kf;
    logic [7:0] d;
    logic [7:0] s;
    logic [8:0] ic;
    oct_lim = enc66 ? `BLOCK_OCTETS : ((i_frame_octets == 8'h00) ? 8'h01 : i_frame_octets);
    frm_lim = enc66 ? `MB_BLOCKS : ((i_frames_per_mf == 9'h000) ? 9'h001 : i_frames_per_mf);
    emb_lim = (enc66 && i_mb_per_emb != 6'h00) ? i_mb_per_emb : 6'h01;
    oct_last = st.oct >= oct_lim - 8'h01;
    frm_last = st.frm >= frm_lim - 9'h001;
    mf_last = oct_last && frm_last && (st.emb >= emb_lim - 6'h01); // RULE17
    sref_rise = st.sref_s && !st.sref_d;
    nl = lane_num(i_transport_mode_select[1:0]); // RULE3 RULE16
    kf = 17'(i_frames_per_mf) * 17'(i_frame_octets);
    d = 8'h00;
    s = 8'h00;
    ic = 9'h000;
    next_st = st;
    // two-flop synchronisers for the pins
    next_st.sync_m = i_link_sync_request_pin_n;
    next_st.sync_s = st.sync_m;
    next_st.sync_d = st.sync_s;
    next_st.sref_m = i_sysref;
    next_st.sref_s = st.sref_m;
    next_st.sref_d = st.sref_s;
    next_st.enc_d = enc66;
    // one counter set for all lanes keeps them aligned
    if (sref_rise) begin // RULE7 RULE11 RULE12
      next_st.oct = 8'h00;
      next_st.frm = 9'h000;
      next_st.emb = 6'h00;
    end else if (oct_last) begin
      next_st.oct = 8'h00;
      if (frm_last) begin
        next_st.frm = 9'h000;
        next_st.emb = mf_last ? 6'h00 : st.emb + 6'h01;
      end else begin
        next_st.frm = st.frm + 9'h001;
      end
    end else begin
      next_st.oct = st.oct + 8'h01;
    end
    // only a long low counts as a resync request, short error pulses pass
    if (!st.sync_s && st.low_cnt != 8'hFF) begin // RULE13
      next_st.low_cnt = st.low_cnt + 8'h01;
    end else if (st.sync_s) begin
      next_st.low_cnt = 8'h00;
    end
    resync = !st.sync_s && st.low_cnt >= 8'(SYNC_MIN_CYC); // RULE5 RULE13
    if (enc66) begin
      next_st.state = jtx_pkg::ST_DATA; // RULE4 RULE6
    end else if (st.enc_d) begin
      next_st.state = jtx_pkg::ST_CGS;
    end else begin
      case (st.state)
        jtx_pkg::ST_CGS: begin
          if (st.sync_s && !st.sync_d) begin // RULE24
            next_st.state = jtx_pkg::ST_WAIT_LMFC;
          end
        end
        jtx_pkg::ST_WAIT_LMFC: begin
          if (resync) begin
            next_st.state = jtx_pkg::ST_CGS;
          end else if (mf_last && !sref_rise) begin // RULE24
            next_st.state = jtx_pkg::ST_ILAS;
            next_st.ilas_mf = 2'h0;
          end
        end
        jtx_pkg::ST_ILAS: begin
          if (resync) begin
            next_st.state = jtx_pkg::ST_CGS;
          end else if (mf_last) begin
            if (st.ilas_mf == `ILAS_LAST_MF) begin // RULE25
              next_st.state = jtx_pkg::ST_DATA;
            end else begin
              next_st.ilas_mf = st.ilas_mf + 2'h1;
            end
          end
        end
        jtx_pkg::ST_DATA: begin
          if (resync) begin
            next_st.state = jtx_pkg::ST_CGS;
          end
        end
        default: next_st.state = jtx_pkg::ST_CGS;
      endcase
    end
    // per-lane character selection
    next_st.tx_valid = 1'b1;
    next_st.blk_start = enc66 && st.oct == 8'h00 && st.state == jtx_pkg::ST_DATA; // RULE4
    for (int l = 0; l < LANES; l++) begin
      next_st.lanes_act[l] = 3'(l) < nl;
      next_st.tx_oct[l] = 8'h00;
      next_st.tx_k[l] = 1'b0;
      next_st.tx_sh[l] = 2'h0;
      d = scr_bus.din[l*8 +: 8];
      s = scr_bus.dout[l*8 +: 8];
      if (3'(l) < nl) begin
        case (st.state)
          jtx_pkg::ST_CGS, jtx_pkg::ST_WAIT_LMFC: begin
            next_st.tx_oct[l] = `K28_5; // RULE23 RULE2
            next_st.tx_k[l] = 1'b1;
          end
          jtx_pkg::ST_ILAS: begin
            ic = ilas_char(st.ilas_mf, st.oct, st.frm, mf_last, oct_lim, frm_lim, nl); // RULE25
            next_st.tx_oct[l] = ic[7:0];
            next_st.tx_k[l] = ic[8];
          end
          jtx_pkg::ST_DATA: begin
            next_st.tx_oct[l] = s; // RULE19
            if (enc66) begin
              // header carries data marker, or the running parity for error correction
              next_st.fec_par[l] = st.fec_par[l] ^ (^s); // RULE9
              if (st.oct == 8'h00) begin
                next_st.tx_sh[l] = i_fec_enable ? {!st.fec_par[l], st.fec_par[l]}
                                                : `SH_DATA; // RULE27 RULE10
              end
            end else if (oct_last) begin
              // end-of-frame alignment characters for link monitoring
              if (!scr_bus.bypass) begin
                next_st.tx_k[l] = (mf_last && s == `K28_3) || s == `K28_7;
              end else if (d == st.prev_last[l]) begin
                next_st.tx_oct[l] = mf_last ? `K28_3 : `K28_7;
                next_st.tx_k[l] = 1'b1;
              end
              next_st.prev_last[l] = d;
            end
          end
          default: next_st.tx_oct[l] = 8'h00;
        endcase
      end
    end
    next_st.lmfc_edge = mf_last;
    next_st.osc_sync = enc66 && i_sync_is_osc_sync && st.sync_d && !st.sync_s; // RULE6
    next_st.cfg_err = !(kf >= `KF_MIN && kf <= `KF_MAX && i_frames_per_mf <= `K_MAX &&
                        i_frames_per_mf != 9'h000); // RULE26
  end

  // every state and output lives on the device clock
  always_ff @(posedge i_core_clk) begin // RULE8
    if (i_srst) begin
      st <= '0;
      st.sync_m <= 1'b1;
      st.sync_s <= 1'b1;
      st.sync_d <= 1'b1;
      st.state <= jtx_pkg::ST_CGS;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign o_smp_ready = buf_rdy;
  assign o_tx_valid = st.tx_valid;
  assign o_tx_octets = st.tx_oct;
  assign o_tx_is_k = st.tx_k;
  assign o_tx_sh = st.tx_sh;
  assign o_tx_block_start = st.blk_start;
  assign o_lanes_active = st.lanes_act;
  assign o_link_state = st.state;
  assign o_lmfc_edge = st.lmfc_edge;
  assign o_osc_sync = st.osc_sync;
  assign o_cfg_error = st.cfg_err;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  cgs_comma_a: assert property ( // RULE23
    st.state == jtx_pkg::ST_CGS && !enc66 |=> o_tx_is_k[0] && o_tx_octets[7:0] == `K28_5)
    else $error("comma missing during code group sync");
  sync_resync_a: assert property ( // RULE5 RULE13
    !enc66 && !st.enc_d && !st.sync_s && st.low_cnt >= 8'(SYNC_MIN_CYC)
    |=> st.state == jtx_pkg::ST_CGS)
    else $error("long sync low did not restart the link");
  ilas_on_lmfc_a: assert property ( // RULE24
    $rose(st.state == jtx_pkg::ST_ILAS) |-> st.oct == 8'h00 && st.frm == 9'h000)
    else $error("alignment sequence not started on a multiframe edge");
  ilas_open_a: assert property ( // RULE25
    st.state == jtx_pkg::ST_ILAS && st.oct == 8'h00 && st.frm == 9'h000 && !enc66
    |=> o_tx_is_k[0] && o_tx_octets[7:0] == `K28_0)
    else $error("multiframe of alignment sequence not opened by K28.0");
  ilas_four_mf_a: assert property ( // RULE25
    $fell(st.state == jtx_pkg::ST_ILAS) && st.state == jtx_pkg::ST_DATA
    |-> $past(st.ilas_mf) == `ILAS_LAST_MF)
    else $error("alignment sequence length wrong");
  sysref_reset_a: assert property ( // RULE7
    st.sref_s && !st.sref_d |=> st.oct == 8'h00 && st.frm == 9'h000 && st.emb == 6'h00)
    else $error("sysref did not reset the framing counters");
  no_sync_66_a: assert property ( // RULE4 RULE6
    enc66 |=> st.state == jtx_pkg::ST_DATA)
    else $error("64b/66b link left data state");
  scr_forced_a: assert property ( // RULE18
    enc66 |-> !scr_bus.bypass)
    else $error("scrambler bypassed in 64b/66b mode");
  ilas_plain_a: assert property ( // RULE20
    st.state != jtx_pkg::ST_DATA |-> !scr_bus.adv)
    else $error("scrambler advanced outside data");
  sync_header_a: assert property ( // RULE27
    o_tx_block_start && o_lanes_active[0] |-> o_tx_sh[0] != o_tx_sh[1])
    else $error("invalid sync header");
  k_range_a: assert property ( // RULE26
    i_frames_per_mf > `K_MAX |=> o_cfg_error)
    else $error("illegal frames per multiframe not flagged");

  ilas_reached_c: cover property ($rose(st.state == jtx_pkg::ST_ILAS));
  data_8b_c: cover property ($rose(st.state == jtx_pkg::ST_DATA) && !enc66);
  align_char_c: cover property (st.state == jtx_pkg::ST_DATA && !enc66 && o_tx_is_k[0]);
  block_66_c: cover property (o_tx_block_start && enc66);

endmodule // jtx_link_tx
`default_nettype wire

/* jtx_rx_model.sv */
// receiver stand-in on the far side of the lanes: drives the sync request
`timescale 1ns/1ps
`default_nettype none
module jtx_rx_model (
  // clock and bench control
  input wire logic i_core_clk,
  input wire logic i_req,
  // lane 0 as sent
  input wire logic [7:0] i_octet,
  input wire logic i_is_k,
  // sync request, active low
  output logic o_sync_n,
  // lane 0 after descrambling
  output logic [7:0] o_plain
);
  logic [57:0] dsr = 58'h0;
  logic low = 1'b0;
  logic comma;
  int seen = 0;
  assign comma = i_is_k && (i_octet == 8'hBC);
  assign o_sync_n = ~low;
  // low on request; release after four commas, or at once if the sender sends none
  always @(posedge i_core_clk) begin
    seen <= comma ? seen + 1 : 0;
    if (i_req) begin
      low <= 1'b1;
    end else if (seen >= 4 || !comma) begin
      low <= 1'b0;
    end
  end
  // self-synchronous descrambler, locks from the received bits alone
  always @(posedge i_core_clk) begin
    logic [57:0] t;
    t = dsr;
    for (int i = 7; i >= 0; i--) begin
      o_plain[i] <= i_octet[i] ^ t[38] ^ t[57];
      t = {t[56:0], i_octet[i]};
    end
    dsr <= t;
  end
endmodule // jtx_rx_model
`default_nettype wire

/* jtx_link_tx_bench.sv */
// self-checking bench for the link transmitter
`timescale 1ns/1ps
`default_nettype none
module jtx_link_tx_bench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic req = 1'b1;
  logic sysref = 1'b0;
  logic scramble_on = 1'b1;
  logic oss = 1'b0;
  logic fec = 1'b0;
  logic [7:0] plain;
  logic valid = 1'b0;
  logic [4:0] mode = 5'h02;
  logic [8:0] k = 9'h008;
  logic [31:0] data = 32'h0;
  logic sync_n, ready, tx_valid, bstart, lmfc, osc, cfg_err;
  logic [31:0] oct;
  logic [3:0] is_k, act, state;
  logic [7:0] sh;
  int errors = 0;
  int cmp_count = 0;
  // 100 MHz device clock
  always #5 core_clk = ~core_clk;
  jtx_link_tx dut_u (.i_core_clk(core_clk), .i_srst(srst), .i_link_sync_request_pin_n(sync_n),
    .i_sysref(sysref), .i_transport_mode_select(mode), .i_scramble_enable(scramble_on),
    .i_fec_enable(fec), .i_sync_is_osc_sync(oss), .i_frame_octets(8'h04),
    .i_frames_per_mf(k), .i_mb_per_emb(6'h01), .i_smp_valid(valid), .i_smp_data(data),
    .o_smp_ready(ready), .o_tx_valid(tx_valid), .o_tx_octets(oct), .o_tx_is_k(is_k),
    .o_tx_sh(sh), .o_tx_block_start(bstart), .o_lanes_active(act), .o_link_state(state),
    .o_lmfc_edge(lmfc), .o_osc_sync(osc), .o_cfg_error(cfg_err));
  jtx_rx_model rx_u (.i_core_clk(core_clk), .i_req(req), .i_octet(oct[7:0]),
    .i_is_k(is_k[0]), .o_sync_n(sync_n), .o_plain(plain));
  // compare and count
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // step to later falling edges, where outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // commas on all lanes while sync is low; buffer takes two words then refuses
  task automatic t_cgs;
    cyc(3);
    chk({tx_valid, state}, 5'h11);
    chk({is_k, oct}, {4'hF, 32'hBCBCBCBC});
    chk(act, 4'hF);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      valid <= 1'b1;
      data <= 32'h11223344 + 32'h44444444 * i;
      cyc(1);
      chk(ready, 1'b1);
    end
    @(posedge core_clk);
    valid <= 1'b0;
    cyc(1);
    chk(ready, 1'b0);
  endtask
  // sync release, wait state, four unscrambled alignment multiframes
  task automatic t_ilas;
    logic saw;
    int n;
    saw = 1'b0;
    n = 0;
    @(posedge core_clk);
    req <= 1'b0;
    while (!(is_k[0] === 1'b1 && oct[7:0] === 8'h1C) && n < 400) begin
      cyc(1);
      n++;
      if (state === 4'b0010) saw = 1'b1;
    end
    chk(saw, 1'b1);
    for (int i = 0; i < 128; i++) begin
      if (i % 32 == 0) chk({is_k, oct}, {4'hF, 32'h1C1C1C1C});
      if (i % 32 == 31) chk({is_k, oct}, {4'hF, 32'h7C7C7C7C});
      if (i == 120) begin
        @(posedge core_clk);
        scramble_on <= 1'b0;
      end
      cyc(1);
    end
    chk(state, 4'b1000);
  endtask
  // the two held words leave whole and in order
  task automatic t_drain;
    int n;
    n = 0;
    while (oct !== 32'h11223344 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(oct, 32'h11223344);
    cyc(1);
    chk({is_k, oct}, {4'h0, 32'h55667788});
    chk(ready, 1'b1);
  endtask
  // a short sync dip is ignored, a long one restarts the link
  task automatic t_resync;
    @(posedge core_clk);
    req <= 1'b1;
    cyc(4);
    @(posedge core_clk);
    req <= 1'b0;
    cyc(15);
    chk(state, 4'b1000);
    @(posedge core_clk);
    req <= 1'b1;
    cyc(16);
    chk(state, 4'b0001);
    chk(oct, 32'hBCBCBCBC);
  endtask
  // cycles from a sysref pulse to the next multiframe edge
  task automatic sref(output int d);
    @(posedge core_clk);
    sysref <= 1'b1;
    repeat (3) @(posedge core_clk);
    sysref <= 1'b0;
    d = 3;
    while (!(lmfc === 1'b1 && d > 8) && d < 100) begin
      cyc(1);
      d++;
    end
  endtask
  // sysref sets the multiframe phase; a multiframe is F*K octets
  task automatic t_lmfc;
    int d1;
    int d2;
    int p;
    sref(d1);
    cyc(13);
    sref(d2);
    chk(d2, d1);
    p = 0;
    cyc(1);
    while (lmfc !== 1'b1 && p < 100) begin
      cyc(1);
      p++;
    end
    chk(p + 1, 32);
  endtask
  // legal frames per multiframe at four octets a frame
  task automatic t_kf;
    logic [8:0] kv [4] = '{9'h004, 9'h005, 9'h100, 9'h101};
    logic ev [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      k <= kv[i];
      cyc(3);
      chk(cfg_err, ev[i]);
    end
    @(posedge core_clk);
    k <= 9'h008;
  endtask
  // 64b/66b: no handshake, header every eight octets, sync only as osc sync
  task automatic t_64b;
    int n;
    @(posedge core_clk);
    mode <= 5'h12;
    cyc(6);
    chk(state, 4'b1000);
    n = 0;
    while (bstart !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(sh, 8'h55);
    cyc(8);
    chk(bstart, 1'b1);
    cyc(1);
    chk({bstart, sh}, 9'h000);
    cyc(16);
    chk(state, 4'b1000);
    chk(plain, 8'h00);
    @(posedge core_clk);
    fec <= 1'b1;
    cyc(1);
    n = 0;
    while (bstart !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk({sh[7] ^ sh[6], sh[5] ^ sh[4], sh[3] ^ sh[2], sh[1] ^ sh[0]}, 4'hF);
    @(posedge core_clk);
    req <= 1'b0;
    oss <= 1'b1;
    cyc(4);
    @(posedge core_clk);
    req <= 1'b1;
    n = 0;
    while (osc !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk(osc, 1'b1);
    @(posedge core_clk);
    mode <= 5'h10;
    cyc(3);
    chk(act, 4'h1);
    chk(oct[31:8], 24'h000000);
    @(posedge core_clk);
    mode <= 5'h11;
    cyc(3);
    chk(act, 4'h3);
  endtask
  // reset, then scenarios in bring-up order
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    cyc(1);
    chk({state, ready}, 5'h03);
    t_cgs;
    t_ilas;
    t_drain;
    t_resync;
    t_lmfc;
    t_kf;
    t_64b;
    tally_and_finish;
  end
  // cut a hung run short
  initial begin
    repeat (6000) @(posedge core_clk);
    errors++;
    tally_and_finish;
  end
endmodule // jtx_link_tx_bench
`default_nettype wire
